/* File: hdl/micw_regs.svh */
`ifndef MICW_REGS_SVH
`define MICW_REGS_SVH
// Summary of operation
// [RQ1] Maskable requests arriving while disabled stay latched, serviced once enabled.
// [RQ2] Service entry pushes PC, X, A, CC, then sets the mask; Y unsaved.
// [RQ3] Return restores context; mask clears only if the stacked mask was zero.
// [RQ4] Fixed priority: reset, trap, then sources down to USB; own vectors.
// [RQ5] Trap instruction always enters service through its vector, ignoring the mask.
// [RQ6] Hardware interrupts are taken only at an instruction boundary.
// [RQ7] Peripheral flag interrupts only when enabled and unmasked; otherwise stays pending.
// [RQ8] Software clears a source by status access then associated register access.
// [RQ9] A clearing sequence discards a pending request so it is never serviced.
// [RQ10] Falling edge on external input sets its latch, bit 3 B, bit 2 A.
// [RQ11] External interrupt requested only when latch set, enabled and unmasked.
// [RQ12] External handler removes the cause by clearing latch or enable bit.
// [RQ13] External enable bits are read/write, bit 1 B, bit 0 A.
// [RQ14] Wait instruction stops CPU processing; clock and peripherals keep running.
// [RQ15] Entering wait clears the mask; any interrupt ends wait and is serviced.
// [RQ16] Reset during wait fetches the reset vector like a normal reset.
// [RQ17] Halt opcode is illegal and requests a device reset.
// [RQ18] Bit 4 selects clock speed: 0 for 12 MHz, 1 for 24 MHz; reset 10h.
// [RQ19] Bit 7 picks primary or alternate vertical sync for the display channel.
// [RQ20] Bit 6 picks sync outputs or flyback inputs for timing measurement.
// [RQ21] Bit 5 enables the divided horizontal sync output onto its pin.
// [RQ22] Every reset sets the interrupt mask bit.
// [RQ23] External inputs pass a two-stage synchroniser before falling-edge detection.

// ----------------------------------------
// Register map
// ----------------------------------------
`define MICW_ADDR_MISC 8'h09
`define MICW_MISC_RST 8'h10
`define MICW_BIT_VSYNC_SEL 7
`define MICW_BIT_MEAS_SEL 6
`define MICW_BIT_HDIV_EN 5
`define MICW_BIT_FAST 4
`define MICW_BIT_B_LATCH 3
`define MICW_BIT_A_LATCH 2
`define MICW_BIT_B_EN 1
`define MICW_BIT_A_EN 0

// ----------------------------------------
// Vectors and counts
// ----------------------------------------
`define MICW_VEC_RESET 16'hfffe
`define MICW_VEC_TRAP 16'hfffc
`define MICW_N_SRC 10
`define MICW_N_PERIPH 8
// Source 0 (highest) in the low word, source 9 (lowest) in the high word
`define MICW_VEC_TABLE {16'hffe6, 16'hffea, 16'hffec, 16'hffee, 16'hfff0, \
   16'hfff2, 16'hfff4, 16'hfff6, 16'hfff8, 16'hfffa}
`define MICW_SAVE_BYTES 3'h5
`endif

/* File: hdl/micw_pkg.sv */
package micw_pkg;
   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_SAVE = 2'h1,
      ST_VECT = 2'h3,
      ST_WAIT = 2'h2
   } micw_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } micw_bus_t;

   typedef struct packed {
      logic instr_done;
      logic trap_exec;
      logic wfi_exec;
      logic halt_decode;
      logic return_from_interrupt_exec;
      logic return_from_interrupt_i_bit;
      logic set_i;
      logic clr_i;
   } micw_cpu_in_t;

   typedef struct packed {
      logic stall;
      logic push_ctx;
      logic vector_load;
      logic [15:0] vector_addr;
      logic i_bit;
      logic reset_req;
      logic in_wait;
   } micw_cpu_out_t;

   typedef struct packed {
      logic ddc_vsync;
      logic tmu_hsync;
      logic tmu_vsync;
      logic divided_hsync_output;
      logic divided_hsync_oe;
      logic fast_mode;
   } micw_route_t;
endpackage : micw_pkg

/* File: hdl/micw_ctrl.sv */
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "micw_regs.svh"
module micw_ctrl (
   input wire logic core_clk,
   input wire logic rst_n,
   input micw_pkg::micw_bus_t bus,
   output logic [7:0] reg_rdata,
   input micw_pkg::micw_cpu_in_t cpu_in,
   output micw_pkg::micw_cpu_out_t cpu_out,
   input wire logic [7:0] periph_flag,
   input wire logic [7:0] periph_enable,
   input wire logic [7:0] periph_clear,
   input wire logic ext_irq_input_a,
   input wire logic ext_irq_input_b,
   input wire logic primary_vsync_input,
   input wire logic alternate_vsync_input,
   input wire logic h_flyback_input,
   input wire logic v_flyback_input,
   input wire logic hsync_from_sync,
   input wire logic vsync_from_sync,
   input wire logic hsync_div_from_sync,
   output micw_pkg::micw_route_t route
);
   import micw_pkg::*;

   localparam int WAIT_EXIT_MAX = 1;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [5:0] sync1;
   logic [5:0] sync2;
   logic [1:0] ext_prev;
   logic edge_a;
   logic edge_b;

   // Two flops per pin, then a third stage on the two external pins for edge detection
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sync1 <= 6'h3f;
         sync2 <= 6'h3f;
         ext_prev <= 2'h3;
      end else begin
         sync1 <= {ext_irq_input_a, ext_irq_input_b, primary_vsync_input,
                   alternate_vsync_input, h_flyback_input, v_flyback_input};
         sync2 <= sync1; // see RQ23
         ext_prev <= sync2[5:4];
      end
   end

   // Falling edges seen once per transition
   assign edge_a = ext_prev[1] & ~sync2[5]; // see RQ23
   assign edge_b = ext_prev[0] & ~sync2[4]; // see RQ23

   // ----------------------------------------
   // Miscellaneous register and bus
   // ----------------------------------------
   logic [7:0] misc;
   logic [7:0] next_misc;
   logic [7:0] next_rdata;
   logic misc_hit_wr;

   assign misc_hit_wr = bus.wr && (bus.addr == `MICW_ADDR_MISC);

   // Write updates, software clears latches by writing zero, edges win
   always_comb begin
      next_misc = misc;
      if (misc_hit_wr) begin
         next_misc[7:4] = bus.wdata[7:4]; // see RQ18
         next_misc[3:2] = misc[3:2] & bus.wdata[3:2];
         next_misc[1:0] = bus.wdata[1:0]; // see RQ13
      end
      if (edge_b) begin
         next_misc[`MICW_BIT_B_LATCH] = 1'b1; // see RQ10
      end
      if (edge_a) begin
         next_misc[`MICW_BIT_A_LATCH] = 1'b1; // see RQ10
      end
      next_rdata = 8'h00;
      if (bus.rd && (bus.addr == `MICW_ADDR_MISC)) begin
         next_rdata = misc;
      end
   end

   // Register update
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         misc <= `MICW_MISC_RST; // see RQ18
         reg_rdata <= 8'h00;
      end else begin
         misc <= next_misc;
         reg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // Signal routing
   // ----------------------------------------
   micw_route_t next_route;

   // Source selection from register bits
   always_comb begin
      next_route.ddc_vsync = misc[`MICW_BIT_VSYNC_SEL] ? sync2[2] : sync2[3]; // see RQ19
      next_route.tmu_hsync = misc[`MICW_BIT_MEAS_SEL] ? sync2[1] : hsync_from_sync; // see RQ20
      next_route.tmu_vsync = misc[`MICW_BIT_MEAS_SEL] ? sync2[0] : vsync_from_sync; // see RQ20
      next_route.divided_hsync_output = misc[`MICW_BIT_HDIV_EN] & hsync_div_from_sync; // see RQ21
      next_route.divided_hsync_oe = misc[`MICW_BIT_HDIV_EN]; // see RQ21
      next_route.fast_mode = misc[`MICW_BIT_FAST]; // see RQ18
   end

   // Routing outputs
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         route <= '0;
      end else begin
         route <= next_route;
      end
   end

   // ----------------------------------------
   // Peripheral pending latches
   // ----------------------------------------
   logic [7:0] flag_q;
   logic [7:0] pend;
   logic [7:0] next_pend;

   // Rising flag sets, clearing sequence discards, a new event wins
   generate
      for (genvar k = 0; k < `MICW_N_PERIPH; k++) begin : g_pend
         always_comb begin
            next_pend[k] = (periph_flag[k] & ~flag_q[k]) | (pend[k] & ~periph_clear[k]); // see RQ1 RQ9
         end
      end
   endgenerate

   // Pending registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         flag_q <= 8'h00;
         pend <= 8'h00;
      end else begin
         flag_q <= periph_flag;
         pend <= next_pend;
      end
   end

   // ----------------------------------------
   // Request priority
   // ----------------------------------------
   logic [`MICW_N_SRC-1:0] src_req;
   logic irq_req;
   logic [15:0] sel_vec;

   // Lowest index is highest priority
   function automatic logic [15:0] micw_pick(input logic [`MICW_N_SRC-1:0] req);
      logic [16*`MICW_N_SRC-1:0] tbl;
      logic [15:0] v;
      tbl = `MICW_VEC_TABLE;
      v = tbl[15:0];
      for (int i = `MICW_N_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            v = tbl[i*16 +: 16]; // see RQ4
         end
      end
      return v;
   endfunction : micw_pick

   // Enabled sources in priority order
   assign src_req = {pend[7:3] & periph_enable[7:3],
                     misc[`MICW_BIT_A_LATCH] & misc[`MICW_BIT_A_EN],
                     misc[`MICW_BIT_B_LATCH] & misc[`MICW_BIT_B_EN],
                     pend[2:0] & periph_enable[2:0]}; // see RQ11 RQ7
   assign irq_req = (|src_req) & ~cpu_out.i_bit; // see RQ7 RQ11
   assign sel_vec = micw_pick(src_req);

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   micw_state_t state;
   micw_state_t next_state;
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   micw_cpu_out_t next_out;

   // Next state and CPU handshake
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_out = cpu_out;
      next_out.reset_req = 1'b0;
      if (cpu_in.return_from_interrupt_exec) begin
         next_out.i_bit = cpu_in.return_from_interrupt_i_bit; // see RQ3
      end else if (cpu_in.set_i) begin
         next_out.i_bit = 1'b1;
      end else if (cpu_in.clr_i) begin
         next_out.i_bit = 1'b0;
      end
      case (state)
         ST_RUN: begin
            if (cpu_in.instr_done) begin // see RQ6
               if (cpu_in.trap_exec) begin
                  next_state = ST_SAVE; // see RQ5
                  next_out.vector_addr = `MICW_VEC_TRAP;
                  next_cnt = 3'h0;
               end else if (cpu_in.halt_decode) begin
                  next_out.reset_req = 1'b1; // see RQ17
               end else if (cpu_in.wfi_exec) begin
                  next_state = ST_WAIT; // see RQ14
                  next_out.i_bit = 1'b0; // see RQ15
               end else if (irq_req) begin
                  next_state = ST_SAVE;
                  next_out.vector_addr = sel_vec; // see RQ4
                  next_cnt = 3'h0;
               end
            end
         end
         ST_SAVE: begin
            next_cnt = cnt + 3'h1;
            if (cnt == `MICW_SAVE_BYTES - 3'h1) begin
               next_state = ST_VECT;
               next_out.i_bit = 1'b1; // see RQ2
            end
         end
         ST_VECT: begin
            next_state = ST_RUN;
         end
         ST_WAIT: begin
            if (irq_req) begin
               next_state = ST_SAVE; // see RQ15
               next_out.vector_addr = sel_vec;
               next_cnt = 3'h0;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
      next_out.push_ctx = (next_state == ST_SAVE); // see RQ2
      next_out.vector_load = (next_state == ST_VECT);
      next_out.stall = (next_state != ST_RUN); // see RQ14
      next_out.in_wait = (next_state == ST_WAIT);
   end

   // Sequencer registers; reset forces the reset vector load
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state <= ST_VECT; // see RQ16
         cnt <= 3'h0;
         cpu_out.stall <= 1'b1;
         cpu_out.push_ctx <= 1'b0;
         cpu_out.vector_load <= 1'b1;
         cpu_out.vector_addr <= `MICW_VEC_RESET; // see RQ16
         cpu_out.i_bit <= 1'b1; // see RQ22
         cpu_out.reset_req <= 1'b0;
         cpu_out.in_wait <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         cpu_out <= next_out;
      end
   end

   // ----------------------------------------
   // Assertion helpers
   // ----------------------------------------
   logic [2:0] busy_cnt;
   logic [2:0] next_busy_cnt;

   // Cycles spent saving and vectoring in one service
   always_comb begin
      next_busy_cnt = 3'h0;
      if (cpu_out.push_ctx || cpu_out.vector_load) begin
         next_busy_cnt = busy_cnt + 3'h1;
      end
   end

   // Helper counter register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         busy_cnt <= 3'h0;
      end else begin
         busy_cnt <= next_busy_cnt;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   reset_mask_set_a: assert property ($past(!rst_n) |-> cpu_out.i_bit && // see RQ22
      cpu_out.vector_addr == 16'hfffe) else $error("mask or vector wrong after reset");
   trap_entry_a: assert property (state == ST_RUN && cpu_in.instr_done && // see RQ5
      cpu_in.trap_exec |=> state == ST_SAVE && cpu_out.vector_addr == 16'hfffc)
      else $error("trap not entered");
   context_push_len_a: assert property ($rose(cpu_out.push_ctx) |-> // see RQ2
      cpu_out.push_ctx [*5] ##1 (!cpu_out.push_ctx && cpu_out.vector_load && cpu_out.i_bit))
      else $error("context save length wrong");
   boundary_only_a: assert property (state == ST_RUN && !cpu_in.instr_done |=> // see RQ6
      state != ST_SAVE) else $error("service started mid instruction");
   masked_hold_a: assert property (state == ST_RUN && cpu_out.i_bit && // see RQ7
      !cpu_in.trap_exec |=> state != ST_SAVE) else $error("masked request serviced");
   edge_latch_a: assert property (edge_a |=> misc[2]) // see RQ10
      else $error("edge latch not set");
   wait_entry_a: assert property (state == ST_RUN && cpu_in.instr_done && // see RQ15
      cpu_in.wfi_exec && !cpu_in.trap_exec && !cpu_in.halt_decode
      |=> state == ST_WAIT && !cpu_out.i_bit && cpu_out.stall)
      else $error("wait entry wrong");
   wait_exit_a: assert property (state == ST_WAIT && irq_req |-> // see RQ15
      ##[1:WAIT_EXIT_MAX] state == ST_SAVE) else $error("wait not left");
   return_from_interrupt_restore_a: assert property (cpu_in.return_from_interrupt_exec && state == ST_RUN && // see RQ3
      !(cpu_in.instr_done && (cpu_in.trap_exec || cpu_in.wfi_exec))
      |=> cpu_out.i_bit == $past(cpu_in.return_from_interrupt_i_bit)) else $error("mask not restored");
   halt_reset_a: assert property (state == ST_RUN && cpu_in.instr_done && // see RQ17
      cpu_in.halt_decode && !cpu_in.trap_exec |=> cpu_out.reset_req ##1 !cpu_out.reset_req)
      else $error("halt did not request reset");
   pend_discard_a: assert property (periph_clear[0] && !(periph_flag[0] && !flag_q[0]) // see RQ9
      |=> !pend[0]) else $error("pending not discarded");
   vsync_route_a: assert property ($past(rst_n) |-> route.ddc_vsync == // see RQ19
      $past(misc[7] ? sync2[2] : sync2[3])) else $error("vsync routing wrong");

   // Service and priority checks
   reset_wait_clear_a: assert property ($past(!rst_n) |-> !cpu_out.in_wait && // see RQ16
      cpu_out.vector_load) else $error("reset vector not loaded after reset");
   service_len_a: assert property (busy_cnt != 3'h7) // see RQ2
      else $error("service save and vector too long");
   wait_stall_a: assert property (state == ST_WAIT |-> cpu_out.stall && // see RQ14
      cpu_out.in_wait) else $error("core not stopped in wait");
   wait_prio_a: assert property (state == ST_WAIT && irq_req && src_req[0] |=> // see RQ4
      cpu_out.vector_addr == 16'hfffa) else $error("wrong vector leaving wait");
   ext_b_prio_a: assert property (state == ST_RUN && cpu_in.instr_done && // see RQ4
      !cpu_in.trap_exec && !cpu_in.halt_decode && !cpu_in.wfi_exec && irq_req &&
      src_req[3] && !(|src_req[2:0]) |=> cpu_out.vector_addr == 16'hfff4)
      else $error("external b vector wrong");
   ext_req_gate_a: assert property (state == ST_RUN && cpu_in.instr_done && // see RQ11 RQ7
      !cpu_in.trap_exec && !(|(pend & periph_enable)) && !(misc[3] && misc[1]) &&
      !(misc[2] && misc[0]) |=> state != ST_SAVE) else $error("disabled source serviced");
   pend_hold_a: assert property (pend[0] && !periph_clear[0] |=> pend[0]) // see RQ1
      else $error("pending request lost");
   set_mask_a: assert property (state == ST_RUN && cpu_in.set_i && !cpu_in.return_from_interrupt_exec &&
      !cpu_in.instr_done |=> cpu_out.i_bit) else $error("mask not set");

   // Register checks
   edge_b_latch_a: assert property (edge_b |=> misc[3]) // see RQ10
      else $error("edge latch b not set");
   latch_hold_a: assert property (misc[3] && !(misc_hit_wr && !bus.wdata[3]) |=> // see RQ10
      misc[3]) else $error("edge latch dropped");
   enable_write_a: assert property (misc_hit_wr |=> // see RQ13
      misc[1:0] == $past(bus.wdata[1:0])) else $error("enable bits not written");
   read_data_a: assert property (bus.rd && bus.addr == 8'h09 |=> // see RQ13
      reg_rdata == $past(misc)) else $error("read data wrong");
   read_idle_a: assert property (!bus.rd |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   unmapped_read_a: assert property (bus.rd && bus.addr != 8'h09 |=>
      reg_rdata == 8'h00) else $error("unmapped read not zero");

   // Routing checks
   fast_route_a: assert property ($past(rst_n) |-> // see RQ18
      route.fast_mode == $past(misc[4])) else $error("speed select not routed");
   meas_route_a: assert property ($past(rst_n) |-> route.tmu_hsync == // see RQ20
      $past(misc[6] ? sync2[1] : hsync_from_sync)) else $error("measure routing wrong");
   hdiv_route_a: assert property ($past(rst_n) |-> // see RQ21
      route.divided_hsync_oe == $past(misc[5])) else $error("divided sync enable wrong");

   // Main scenarios reached
   trap_seen_c: cover property (state == ST_RUN && cpu_in.instr_done && cpu_in.trap_exec);
   wait_exit_c: cover property (state == ST_WAIT ##1 state == ST_SAVE);
   ext_irq_c: cover property (state == ST_SAVE && cpu_out.vector_addr == 16'hfff2);
   nested_return_from_interrupt_c: cover property (cpu_in.return_from_interrupt_exec && !cpu_in.return_from_interrupt_i_bit);
   halt_reset_c: cover property (cpu_out.reset_req);
endmodule : micw_ctrl

/* File: verification/micw_cpu_model.sv */
`timescale 1ns/1ps
module micw_cpu_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input micw_pkg::micw_cpu_out_t cpu_out,
   output micw_pkg::micw_cpu_in_t cpu_in,
   output logic [7:0] periph_clear
);
   import micw_pkg::*;
   int push_cnt = 0;
   int vec_cnt = 0;
   logic [15:0] last_vec = 16'h0000;
   // Quiet core at time zero
   initial begin
      cpu_in = '0;
      periph_clear = 8'h00;
   end
   // Counts stacked bytes and vector fetches
   always @(posedge core_clk) begin
      push_cnt <= push_cnt + int'(cpu_out.push_ctx);
      if (cpu_out.vector_load) begin
         vec_cnt <= vec_cnt + 1;
         last_vec <= cpu_out.vector_addr;
      end
   end
   // One core event, issued only while the core may run
   task automatic issue(input logic [7:0] ev);
      @(posedge core_clk);
      while (cpu_out.stall) @(posedge core_clk);
      cpu_in <= micw_cpu_in_t'(ev);
      @(posedge core_clk);
      cpu_in <= '0;
   endtask : issue
   // Status access then data access, seen as one pulse
   task automatic clear_src(input int k);
      @(posedge core_clk);
      periph_clear[k] <= 1'b1;
      @(posedge core_clk);
      periph_clear <= 8'h00;
   endtask : clear_src
endmodule : micw_cpu_model

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import micw_pkg::*;
   localparam logic [7:0] OP_DONE = 8'h80;
   localparam logic [7:0] OP_TRAP = 8'hc0;
   localparam logic [7:0] OP_WFI = 8'ha0;
   localparam logic [7:0] OP_HALT = 8'h90;
   localparam logic [7:0] OP_RET0 = 8'h08;
   localparam logic [7:0] OP_RET1 = 8'h0c;
   localparam logic [7:0] OP_SETI = 8'h02;
   localparam logic [7:0] OP_CLRI = 8'h01;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   micw_bus_t bus = '0;
   logic [7:0] reg_rdata;
   micw_cpu_in_t cpu_in;
   micw_cpu_out_t cpu_out;
   logic [7:0] periph_flag = 8'h00;
   logic [7:0] periph_enable = 8'h00;
   logic [7:0] periph_clear;
   logic ext_irq_input_a = 1'b1;
   logic ext_irq_input_b = 1'b1;
   logic [6:0] sync_in = 7'h33;
   micw_route_t route;
   int error_cnt = 0;
   int checks_done = 0;
   int p0;
   int v0;
   // ----------------------------------------
   // Clock, design and core model
   // ----------------------------------------
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   micw_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .reg_rdata(reg_rdata),
      .cpu_in(cpu_in), .cpu_out(cpu_out), .periph_flag(periph_flag),
      .periph_enable(periph_enable), .periph_clear(periph_clear),
      .ext_irq_input_a(ext_irq_input_a), .ext_irq_input_b(ext_irq_input_b),
      .primary_vsync_input(sync_in[6]), .alternate_vsync_input(sync_in[5]),
      .h_flyback_input(sync_in[4]), .v_flyback_input(sync_in[3]),
      .hsync_from_sync(sync_in[2]), .vsync_from_sync(sync_in[1]),
      .hsync_div_from_sync(sync_in[0]), .route(route));
   micw_cpu_model model (.core_clk(core_clk), .rst_n(rst_n), .cpu_out(cpu_out),
      .cpu_in(cpu_in), .periph_clear(periph_clear));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask : reg_wr
   // Read data stand only in the cycle after the strobe
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus.rd <= 1'b0;
      @(negedge core_clk);
      chk_val({8'h00, reg_rdata}, {8'h00, exp});
   endtask : chk_reg
   task automatic snap;
      p0 = model.push_cnt;
      v0 = model.vec_cnt;
   endtask : snap
   // Waits for a service to end, then checks stacking, vector and mask
   task automatic svc(input logic [15:0] vec);
      int n;
      n = 0;
      @(negedge core_clk);
      while (cpu_out.stall === 1'b1 && n < 60) begin
         @(negedge core_clk);
         n++;
      end
      chk_val(16'(model.push_cnt - p0), 16'h0005);
      chk_val(model.last_vec, vec);
      chk_val(16'(model.vec_cnt - v0), 16'h0001);
      chk_val({15'h0, cpu_out.i_bit}, 16'h0001);
      snap();
   endtask : svc
   task automatic idle_chk;
      repeat (4) @(negedge core_clk);
      chk_val({15'h0, cpu_out.stall}, 16'h0000);
      chk_val(16'(model.vec_cnt - v0), 16'h0000);
   endtask : idle_chk
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk_val(cpu_out.vector_addr, 16'hfffe);
      chk_val({14'h0, cpu_out.i_bit, cpu_out.in_wait}, 16'h0002);
      @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (2) @(negedge core_clk);
      snap();
   endtask : do_reset
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      do_reset();
      chk_val({15'h0, route.fast_mode}, 16'h0001);
      chk_val(model.last_vec, 16'hfffe);
      chk_reg(8'h09, 8'h10);
      reg_wr(8'h09, 8'hff);
      reg_wr(8'h08, 8'h00);
      chk_reg(8'h08, 8'h00);
      chk_reg(8'h09, 8'hf3);
      chk_val({10'h0, route}, 16'h0037);
      reg_wr(8'h09, 8'h03);
      repeat (5) @(negedge core_clk);
      chk_val({10'h0, route}, 16'h0008);
      reg_wr(8'h09, 8'h10);
      $display("test registers done");
      model.issue(OP_TRAP);
      svc(16'hfffc);
      model.issue(OP_RET1);
      @(negedge core_clk);
      chk_val({15'h0, cpu_out.i_bit}, 16'h0001);
      model.issue(OP_RET0);
      @(negedge core_clk);
      chk_val({15'h0, cpu_out.i_bit}, 16'h0000);
      $display("test trap done");
      model.issue(OP_SETI);
      periph_enable <= 8'h24;
      periph_flag <= 8'h24;
      model.issue(OP_DONE);
      idle_chk();
      model.issue(OP_CLRI);
      idle_chk();
      model.issue(OP_DONE);
      svc(16'hfff6);
      model.clear_src(2);
      model.issue(OP_RET0);
      model.issue(OP_DONE);
      svc(16'hffec);
      model.clear_src(5);
      periph_flag <= 8'h80;
      repeat (3) @(posedge core_clk);
      model.clear_src(7);
      periph_enable <= 8'h80;
      model.issue(OP_RET0);
      model.issue(OP_DONE);
      idle_chk();
      $display("test peripherals done");
      @(posedge core_clk);
      ext_irq_input_a <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk_reg(8'h09, 8'h14);
      @(posedge core_clk);
      ext_irq_input_b <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk_reg(8'h09, 8'h1c);
      model.issue(OP_DONE);
      idle_chk();
      reg_wr(8'h09, 8'h1f);
      model.issue(OP_DONE);
      svc(16'hfff4);
      reg_wr(8'h09, 8'h17);
      model.issue(OP_RET0);
      model.issue(OP_DONE);
      svc(16'hfff2);
      reg_wr(8'h09, 8'h13);
      model.issue(OP_RET0);
      $display("test external done");
      model.issue(OP_SETI);
      periph_flag <= 8'h00;
      periph_enable <= 8'h01;
      model.issue(OP_WFI);
      @(negedge core_clk);
      chk_val({13'h0, cpu_out.in_wait, cpu_out.stall, cpu_out.i_bit}, 16'h0006);
      chk_reg(8'h09, 8'h13);
      @(posedge core_clk);
      periph_flag <= 8'h01;
      svc(16'hfffa);
      chk_val({15'h0, cpu_out.in_wait}, 16'h0000);
      model.clear_src(0);
      model.issue(OP_RET0);
      model.issue(OP_WFI);
      do_reset();
      chk_reg(8'h09, 8'h10);
      $display("test wait done");
      model.issue(OP_HALT);
      @(negedge core_clk);
      chk_val({15'h0, cpu_out.reset_req}, 16'h0001);
      @(negedge core_clk);
      chk_val({15'h0, cpu_out.reset_req}, 16'h0000);
      $display("test halt done");
      report_and_stop();
   end
   // Cuts a hang short
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      report_and_stop();
   end
endmodule : testbench
